// file: inc/ov_fault_pkg.sv
// Constants, types and helpers for the overvoltage fault response block
package ov_fault_pkg;
   // Command code of the fault action configuration byte
   localparam logic [7:0] CFG_OFFSET = 8'h41;
   // Reset value of the configuration byte (ignore, no retry, x1)
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Field positions inside the configuration byte
   localparam int RESP_LSB = 6;
   localparam int RETRY_LSB = 3;
   localparam int TIME_LSB = 0;
   // Response codes
   localparam logic [1:0] RESP_IGNORE = 2'h0;
   localparam logic [1:0] RESP_CONTINUE = 2'h1;
   localparam logic [1:0] RESP_RETRY = 2'h2;
   localparam logic [1:0] RESP_HOLD = 2'h3;
   // Retry codes with special meaning
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // Widths of the delay unit and of the loaded cycle count
   localparam int UNIT_W = 16;
   localparam int LOAD_W = 24;

   // Controller states
   typedef enum logic [2:0] {
      RUN = 3'h0,
      CONT_DLY = 3'h1,
      OFF_WAIT = 3'h2,
      RETRY_ON = 3'h3,
      LATCH_OFF = 3'h4,
      HOLD_OFF = 3'h5,
      CMD_OFF = 3'h6
   } ctrl_state_t;

   // Time field to multiplier of the delay unit
   function automatic logic [7:0] delay_mult(input logic [2:0] code);
      logic [7:0] m;
      m = 8'h01;
      case (code)
         3'h0: m = 8'h01;
         3'h1: m = 8'h02;
         3'h2: m = 8'h04;
         3'h3: m = 8'h10;
         3'h4: m = 8'h08;
         3'h5: m = 8'h20;
         3'h6: m = 8'h40;
         default: m = 8'h80;
      endcase
      return m;
   endfunction
endpackage

// file: verilog/ov_delay_timer.sv
// One-shot down counter giving a single done pulse after a loaded delay
`timescale 1ns/1ps
`default_nettype none
module ov_delay_timer
   import ov_fault_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic start,
   input wire logic [ov_fault_pkg::LOAD_W-1:0] loadCycles,
   // Result
   output logic done
);
   typedef struct packed {
      logic [LOAD_W-1:0] cnt;
      logic run;
      logic done;
   } timer_state_t;

   timer_state_t q, d;

   // Restart wins over a running count; zero load expires next cycle
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (start) begin
         d.cnt = loadCycles;
         d.run = 1'b1;
      end else if (q.run) begin
         if (q.cnt <= {{(LOAD_W-1){1'b0}}, 1'b1}) begin
            d.run = 1'b0;
            d.done = 1'b1;
         end else begin
            d.cnt = q.cnt - {{(LOAD_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;
endmodule
`default_nettype wire

// file: verilog/ov_fault_response_retry_logic.sv
// Overvoltage fault response controller with delayed action and retries
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Response 00 keeps the output enabled and ignores the fault.
// - Response 01 runs on for the delay, then retries if fault persists.
// - Response 10 disables output at once, then follows retry count.
// - Response 11 holds output off while fault present, resumes after.
// - Clear by status clear, clear-faults, reset, or off-then-on command.
// - Retry 000 makes no restart; output stays off until cleared.
// - Retry 001..011 allow one to three restarts, then latch off.
// - Retry 111 restarts without limit.
// - Attempt starts spaced by multiplier times delay unit.
// - Time codes map to 1,2,4,16,8,32,64,128 unit multipliers.
// - Retry 100..110 allow four to six restarts, then latch off.
// - Retrying stops on off command or another shutdown fault.
module ov_fault_response_retry_logic
   import ov_fault_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Configuration byte access by command code
   input wire logic [7:0] cmdCode,
   input wire logic cfgWrite,
   input wire logic [7:0] cfgWrData,
   output logic [7:0] cfgRdData,
   // Delay unit in clock cycles, from the time unit setting
   input wire logic [ov_fault_pkg::UNIT_W-1:0] unitCycles,
   // Fault detection and clear sources
   input wire logic ovDetect,
   input wire logic statusBitClear,
   input wire logic clearFaultsCmd,
   input wire logic otherFaultShutdown,
   // Combined pin and operation on command, high means on
   input wire logic outputOnCmd,
   // Results
   output logic outputEnable,
   output logic ovFaultStatus,
   output logic [2:0] attemptCount,
   output logic [2:0] ctrlState
);
   typedef struct packed {
      ctrl_state_t st;
      logic [7:0] cfg;
      logic [7:0] rd;
      logic [2:0] tries;
      logic latched;
      logic outEn;
      logic cmdPrev;
   } ctrl_regs_t;

   ctrl_regs_t q, d;
   logic startT;
   logic timerDone;
   logic [1:0] resp;
   logic [2:0] retry;
   logic [2:0] timeCode;
   logic [LOAD_W-1:0] loadCycles;
   logic cmdOnEdge;
   logic clearEvt;

   // Configuration fields
   assign resp = q.cfg[RESP_LSB +: 2];
   assign retry = q.cfg[RETRY_LSB +: 3];
   assign timeCode = q.cfg[TIME_LSB +: 3];

   assign loadCycles = {16'h0000, delay_mult(timeCode)} *
                       {8'h00, unitCycles};

   assign cmdOnEdge = outputOnCmd & ~q.cmdPrev;
   assign clearEvt = statusBitClear | clearFaultsCmd | cmdOnEdge;

   // Timer restarts on entry into a timed state, except OFF_WAIT from RETRY_ON, which keeps the running interval unless it has just run out
   ov_delay_timer u_timer (
      .clk(clk),
      .resetn(resetn),
      .start(startT),
      .loadCycles(loadCycles),
      .done(timerDone)
   );

   // Next state of the controller and its registers
   always_comb begin
      d = q;
      startT = 1'b0;
      d.cmdPrev = outputOnCmd;
      if (cfgWrite && cmdCode == CFG_OFFSET) begin
         d.cfg = cfgWrData;
      end
      d.rd = (cmdCode == CFG_OFFSET) ? q.cfg : 8'h00;
      // Set wins over clear so a fault present now is never lost
      d.latched = (q.latched & ~clearEvt) | ovDetect;
      unique case (q.st)
         RUN: begin
            if (ovDetect) begin
               unique case (resp)
                  RESP_IGNORE: d.st = RUN;
                  RESP_CONTINUE: begin
                     d.st = CONT_DLY;
                     startT = 1'b1;
                  end
                  RESP_RETRY: begin
                     d.tries = 3'h0;
                     if (retry == RETRY_NONE) begin
                        d.st = LATCH_OFF;
                     end else begin
                        d.st = OFF_WAIT;
                        startT = 1'b1;
                     end
                  end
                  RESP_HOLD: d.st = HOLD_OFF;
               endcase
            end
         end
         CONT_DLY: begin
            if (timerDone) begin
               if (ovDetect) begin
                  d.tries = 3'h0;
                  if (retry == RETRY_NONE) begin
                     d.st = LATCH_OFF;
                  end else begin
                     d.st = OFF_WAIT;
                     startT = 1'b1;
                  end
               end else begin
                  d.st = RUN;
               end
            end
         end
         OFF_WAIT: begin
            if (timerDone) begin
               d.st = RETRY_ON;
               startT = 1'b1;
               // Saturate so continuous retry never wraps the count
               if (q.tries != 3'h7) begin
                  d.tries = q.tries + 3'h1;
               end
            end
         end
         RETRY_ON: begin
            if (ovDetect) begin
               if (retry != RETRY_FOREVER && q.tries >= retry) begin
                  d.st = LATCH_OFF;
               end else begin
                  d.st = OFF_WAIT;
                  // Keep the running interval unless it just ran out
                  startT = timerDone;
               end
            end else if (timerDone) begin
               d.st = RUN;
               d.tries = 3'h0;
            end
         end
         LATCH_OFF: begin
            if (clearEvt) begin
               d.st = RUN;
               d.tries = 3'h0;
            end
         end
         HOLD_OFF: begin
            if (!ovDetect) begin
               d.st = RUN;
            end
         end
         CMD_OFF: begin
            if (cmdOnEdge) begin
               d.st = RUN;
               d.tries = 3'h0;
            end
         end
         default: d.st = LATCH_OFF;
      endcase
      if (!outputOnCmd) begin
         d.st = CMD_OFF;
      end else if (otherFaultShutdown && q.st != CMD_OFF) begin
         d.st = LATCH_OFF;
      end
      // Output follows the next state, so it changes with the state
      d.outEn = (d.st == RUN) || (d.st == CONT_DLY) ||
                (d.st == RETRY_ON);
   end

   // All state in one register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         q.st <= CMD_OFF;
         q.cfg <= CFG_RESET;
         q.rd <= 8'h00;
         q.tries <= 3'h0;
         q.latched <= 1'b0;
         q.outEn <= 1'b0;
         q.cmdPrev <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // Registered outputs
   assign outputEnable = q.outEn;
   assign ovFaultStatus = q.latched;
   assign attemptCount = q.tries;
   assign ctrlState = q.st;
   assign cfgRdData = q.rd;
endmodule
`default_nettype wire

// file: test/ov_fault_props.sv
// Concurrent checks on the overvoltage fault response ports
`timescale 1ns/1ps
`default_nettype none
module ov_fault_props (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Host access
   input wire logic [7:0] cmdCode,
   input wire logic cfgWrite,
   input wire logic [7:0] cfgWrData,
   // Unit inputs
   input wire logic ovDetect,
   input wire logic statusBitClear,
   input wire logic clearFaultsCmd,
   input wire logic otherFaultShutdown,
   input wire logic outputOnCmd,
   // Results
   input wire logic outputEnable,
   input wire logic ovFaultStatus,
   input wire logic [2:0] ctrlState
);
   logic [7:0] cfg_q;
   logic run;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Own copy of the byte, so checks never trust the read path
   always_ff @(posedge clk) begin
      if (!resetn) cfg_q <= 8'h00;
      else if (cfgWrite && cmdCode == 8'h41) cfg_q <= cfgWrData;
   end
   assign run = outputOnCmd && !otherFaultShutdown;
   sequence hold_gone;
      ctrlState == 3'h5 && !ovDetect && run;
   endsequence
   sequence latched_quiet;
      ctrlState == 3'h4 && !statusBitClear && !clearFaultsCmd && outputOnCmd;
   endsequence
   a_ignore_stays_on: assert property (
      ctrlState == 3'h0 && cfg_q[7:6] == 2'h0 && run |=> outputEnable)
      else $error("output dropped on ignored fault");
   a_disable_at_once: assert property (
      ctrlState == 3'h0 && ovDetect && cfg_q[7:6] == 2'h2 && run
      |=> !outputEnable) else $error("output not cut");
   a_hold_resumes: assert property (hold_gone |=> outputEnable)
      else $error("output not resumed");
   a_latch_stays_off: assert property (
      latched_quiet |=> ctrlState == 3'h4 && !outputEnable)
      else $error("latched state left");
   a_clear_resumes: assert property (
      ctrlState == 3'h4 && (clearFaultsCmd || statusBitClear) && run
      && !ovDetect |=> ctrlState == 3'h0) else $error("clear ignored");
   a_cmd_off_stops: assert property (
      !outputOnCmd |=> !outputEnable && ctrlState == 3'h6)
      else $error("off command ignored");
   a_other_fault_off: assert property (
      otherFaultShutdown && outputOnCmd && outputEnable
      |=> ctrlState == 3'h4) else $error("other fault ignored");
   a_status_sets: assert property (ovDetect |=> ovFaultStatus)
      else $error("status not set");
endmodule
bind ov_fault_response_retry_logic ov_fault_props props_u (.clk, .resetn,
   .cmdCode, .cfgWrite, .cfgWrData, .ovDetect, .statusBitClear,
   .clearFaultsCmd, .otherFaultShutdown, .outputOnCmd, .outputEnable,
   .ovFaultStatus, .ctrlState);
`default_nettype wire

// file: test/ov_host_model.sv
// Host model that writes and reads the configuration byte
`timescale 1ns/1ps
`default_nettype none
module ov_host_model (
   // Clock
   input wire logic clk,
   // Access signals
   output logic [7:0] cmdCode,
   output logic cfgWrite,
   output logic [7:0] cfgWrData,
   input wire logic [7:0] cfgRdData
);
   initial begin
      cmdCode = 8'h00;
      cfgWrite = 1'b0;
      cfgWrData = 8'h00;
   end
   // One strobe; data inverted after, so stale values never match
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
      @(negedge clk);
      cmdCode = cmd;
      cfgWrData = d;
      cfgWrite = 1'b1;
      @(negedge clk);
      cfgWrite = 1'b0;
      cfgWrData = ~d;
   endtask
   // Read data is registered, so two edges pass first
   task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
      @(negedge clk);
      cmdCode = cmd;
      repeat (2) @(negedge clk);
      d = cfgRdData;
   endtask
endmodule
`default_nettype wire

// file: test/ov_fault_response_retry_logic_tb_top.sv
// Self-checking bench for the overvoltage fault response block
`timescale 1ns/1ps
`default_nettype none
module ov_fault_response_retry_logic_tb_top;
   logic clk = 1'b0, resetn = 1'b0, ovDetect = 1'b0, statusBitClear = 1'b0;
   logic clearFaultsCmd = 1'b0, otherFaultShutdown = 1'b0, outputOnCmd = 1'b1;
   logic [7:0] cmdCode, cfgWrData, cfgRdData, rdv;
   logic cfgWrite, outputEnable, ovFaultStatus, lastEn;
   logic [2:0] attemptCount, ctrlState;
   logic [15:0] unitCycles = 16'h0002;
   logic [2:0] tc [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   int mu [8] = '{1, 2, 4, 16, 8, 32, 64, 128};
   int n_mismatch = 0, checked = 0, rises, last, gap, n;
   always #25 clk = ~clk;
   ov_host_model host_u (.clk, .cmdCode, .cfgWrite, .cfgWrData, .cfgRdData);
   ov_fault_response_retry_logic dut_u (.clk, .resetn, .cmdCode, .cfgWrite,
      .cfgWrData, .cfgRdData, .unitCycles, .ovDetect,
      .statusBitClear, .clearFaultsCmd, .otherFaultShutdown, .outputOnCmd,
      .outputEnable, .ovFaultStatus, .attemptCount, .ctrlState);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Drive the fault line, counting enable rises and their spacing
   task automatic episode(input logic [7:0] c, input int hi, input int tot);
      host_u.wr(8'h41, c);
      rises = 0;
      last = 0;
      lastEn = outputEnable;
      for (int i = 0; i < tot; i++) begin
         @(negedge clk);
         ovDetect = (i < hi);
         if (outputEnable && !lastEn) begin
            rises++;
            gap = i - last;
            last = i;
         end
         lastEn = outputEnable;
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   // Off then on command clears a latched fault
   task automatic cycle_on();
      @(negedge clk);
      ovDetect = 1'b0;
      outputOnCmd = 1'b0;
      repeat (2) @(negedge clk);
      chk(8'(ctrlState), 8'h06);
      outputOnCmd = 1'b1;
      repeat (2) @(negedge clk);
      chk(8'(outputEnable), 8'h01);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      // Reset value, ignored unmapped write, read-back
      host_u.rd(8'h41, rdv);
      chk(rdv, 8'h00);
      host_u.wr(8'h40, 8'hFF);
      host_u.rd(8'h41, rdv);
      chk(rdv, 8'h00);
      host_u.rd(8'h40, rdv);
      chk(rdv, 8'h00);
      host_u.wr(8'h41, 8'hA5);
      host_u.rd(8'h41, rdv);
      chk(rdv, 8'hA5);
      episode(8'h00, 3, 10);
      chk(8'(rises), 8'h00);
      chk(8'(ovFaultStatus), 8'h01);
      pulse(statusBitClear);
      chk(8'(ovFaultStatus), 8'h00);
      episode(8'h80, 1, 20);
      chk(8'(rises), 8'h00);
      chk(8'(ctrlState), 8'h04);
      pulse(clearFaultsCmd);
      chk(8'(outputEnable), 8'h01);
      episode(8'h90, 60, 60);
      chk(8'(rises), 8'h02);
      chk(8'(attemptCount), 8'h02);
      cycle_on();
      // Five attempts, then latched off
      episode(8'hA8, 60, 60);
      chk(8'(rises), 8'h05);
      chk(8'(attemptCount), 8'h05);
      chk(8'(ctrlState), 8'h04);
      chk(8'(gap >= 2 && gap <= 5), 8'h01);
      cycle_on();
      // Unlimited retries; spacing follows the time code
      foreach (tc[k]) begin
         // Odd codes use a longer unit so the unit input counts too
         unitCycles = (k % 2) ? 16'h0003 : 16'h0002;
         n = mu[k] * int'(unitCycles);
         episode({5'h17, tc[k]}, 9000, 9 * (n + 3));
         chk(8'(gap >= n && gap <= n + 3), 8'h01);
         chk(8'(rises >= 7), 8'h01);
         cycle_on();
      end
      unitCycles = 16'h0002;
      // Fault gone before the delay ends: no action
      episode(8'h52, 3, 20);
      chk(8'(rises), 8'h00);
      chk(8'(ctrlState), 8'h00);
      episode(8'h52, 60, 4);
      chk(8'(outputEnable), 8'h01);
      episode(8'h52, 60, 60);
      chk(8'(rises), 8'h02);
      cycle_on();
      episode(8'hC0, 5, 10);
      chk(8'(rises), 8'h01);
      episode(8'h88, 2, 30);
      chk(8'(ctrlState), 8'h00);
      chk(8'(attemptCount), 8'h00);
      pulse(otherFaultShutdown);
      chk(8'(ctrlState), 8'h04);
      // Mid-run reset clears the latched fault
      @(negedge clk);
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      chk(8'(ovFaultStatus), 8'h00);
      chk(8'(outputEnable), 8'h01);
      final_report();
   end
endmodule
`default_nettype wire
